// ==== common/dam_pkg.sv ====
// types shared by the address map and read prediction block
package dam_pkg;
  typedef enum logic [1:0] {DAM_CMD_NOP, DAM_CMD_ACT, DAM_CMD_RD, DAM_CMD_WR} dam_cmd_e;
  typedef enum logic [1:0] {DAM_ST_IDLE, DAM_ST_DISC, DAM_ST_RUN} dam_state_e;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic simd;
  } dam_req_s;
  typedef struct packed {
    dam_cmd_e cmd;
    logic cs_n;
    logic [2:0] ba;
    logic [14:0] addr;
  } dam_pins_s;
endpackage

// ==== common/dam_regs.svh ====
// register offsets, field positions, reset values and cycle counts
`ifndef DAM_REGS_SVH
`define DAM_REGS_SVH
`define DAM_CTRL0_OFS 12'h000
`define DAM_STAT_OFS 12'h004
`define DAM_BC_LSB 0
`define DAM_CAW_LSB 2
`define DAM_RAW_LSB 4
`define DAM_X16_BIT 9
`define DAM_OPT_BIT 10
`define DAM_ILV_BIT 14
`define DAM_REGBUF_BIT 24
`define DAM_STRIDE_LSB 25
`define DAM_SREF_BIT 27
`define DAM_CTRL0_RST 32'h0200024A
`define DAM_CTRL0_MASK 32'h0F00467F
`define DAM_COL_BASE 4'h8
`define DAM_ROW_BASE 4'h8
`define DAM_RD_CYCLES 11
`define DAM_COL0_CYC 2
`define DAM_CCD 2
`define DAM_DISCARD_MAX 8
`endif

// ==== verification/dam_mem_model.sv ====
// behavioural model of the memory parts behind the command pins
module dam_mem_model (
  // memory clock
  input wire logic memory_clock_in,
  // command pins from the controller
  input wire dam_pkg::dam_pins_s pins_in,
  // last captured addresses
  output logic [2:0] ba_out,
  output logic [14:0] row_out,
  output logic [14:0] col_out,
  output logic [14:0] col_prev_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ba_out = 3'h0;
    row_out = 15'h0000;
    col_out = 15'h0000;
    col_prev_out = 15'h0000;
  end
  // the parts sample on the clock rise; a command with the select high is not seen at all
  always @(posedge memory_clock_in) begin
    if (pins_in.cs_n === 1'b0) begin
      if (pins_in.cmd === dam_pkg::DAM_CMD_ACT) begin
        ba_out <= pins_in.ba;
        row_out <= pins_in.addr;
      end else if (pins_in.cmd !== dam_pkg::DAM_CMD_NOP) begin
        col_prev_out <= col_out;
        col_out <= pins_in.addr;
      end
    end
  end
endmodule

// ==== verification/tb_dam_ctrl.sv ====
// self-checking testbench of the address map and read prediction block
module tb_dam_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] c;
    logic [2:0] ba;
    logic [14:0] row;
    logic [14:0] col;
    logic [11:0] pg;
  } dam_row_s;
  // kept far from any external bank end so prediction is legal here
  localparam logic [31:0] ADR = 32'h00A5C396;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid = 1'b0;
  dam_pkg::dam_req_s req = '0;
  logic ack;
  logic [3:0] burst;
  logic mclk = 1'b0;
  dam_pkg::dam_pins_s pins;
  logic aref_req = 1'b0;
  logic aref;
  logic [2:0] m_ba;
  logic [14:0] m_row;
  logic [14:0] m_col;
  logic [14:0] m_colp;
  int error_cnt = 0;
  int n_compared = 0;
  dam_row_s tbl [4] = '{
    '{32'h0200024A, ADR[11:9], {3'h0, ADR[23:12]}, {5'h00, ADR[8:0], 1'b0}, 12'h200},
    '{32'h0200024D, {1'b0, ADR[11:10]}, {3'h0, ADR[23:12]},
      {3'h0, ADR[9], 1'b0, ADR[8:0], 1'b0}, 12'h400},
    '{32'h0200424A, ADR[23:21], {3'h0, ADR[20:9]}, {5'h00, ADR[8:0], 1'b0}, 12'h200},
    '{32'h0200424D, {1'b0, ADR[23:22]}, {3'h0, ADR[21:10]},
      {3'h0, ADR[9], 1'b0, ADR[8:0], 1'b0}, 12'h400}};

  dam_ctrl dam_ctrl_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .req_valid_in(req_valid), .req_in(req), .ack_out(ack), .burst_use_out(burst),
    .memory_clock_in(mclk), .pins_out(pins), .auto_refresh_req_in(aref_req),
    .auto_refresh_out(aref));
  dam_mem_model dam_mem_model_inst (.memory_clock_in(mclk), .pins_in(pins), .ba_out(m_ba),
    .row_out(m_row), .col_out(m_col), .col_prev_out(m_colp));

  always #50 sys_clk_in = ~sys_clk_in;
  // odd start offset keeps the memory clock out of step with the system clock
  initial begin
    #137;
    forever #400 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk("pready wait", 1, 0);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, 12'h000, d, q, e);
  endtask

  // n: cycles until ack, m: cycle at which the row opened (-1 if never)
  task automatic acc(input logic w, input logic [31:0] a, input logic s, output int n,
      output int m);
    n = 0;
    m = -1;
    @(posedge sys_clk_in);
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, simd: s};
    do begin
      @(negedge sys_clk_in);
      n++;
      if (m < 0 && pins.cmd === dam_pkg::DAM_CMD_ACT) m = n;
    end while (ack !== 1'b1 && n < 400);
    if (ack !== 1'b1) chk("ack wait", 1, 0);
  endtask

  task automatic rd(input logic [31:0] a, input logic s, output int n, output int m);
    acc(1'b0, a, s, n, m);
  endtask

  task automatic idle();
    @(posedge sys_clk_in);
    req_valid <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    end_sim();
  end

  initial begin
    logic [31:0] q;
    logic e;
    int n;
    int m;
    int t;
    int m0;
    repeat (19) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk("reset pins", 19'h40000, {pins.cs_n, pins.ba, pins.addr});
    chk("reset outputs", 32'h0000010F, {pready, ack, aref, pins.cmd, burst});
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl0 reset", 32'h0200024A, q);
    apb(1'b1, 12'h000, 32'hFFFFFFFF, q, e);
    apb(1'b1, 12'h008, 32'h0, q, e);
    chk("unmapped write error", 1, e);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk("unmapped read error", 1, e);
    chk("unmapped read data", 0, q);
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl0 mask", 32'h0F00467F, q);
    foreach (tbl[i]) begin
      cfg(tbl[i].c);
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk("page size", tbl[i].pg, q[27:16]);
      rd(ADR, 1'b0, n, m);
      idle();
      chk("read ticks", 11, (n - m + 4) / 8 + 1);
      chk("bank", tbl[i].ba, m_ba);
      chk("row", tbl[i].row, m_row);
      chk("column low half", tbl[i].col, m_colp);
      chk("column high half", tbl[i].col | 15'h0001, m_col);
    end
    cfg(32'h0300024A);
    rd(ADR, 1'b0, n, m);
    idle();
    chk("buffered ticks", 12, (n - m + 4) / 8 + 1);
    cfg(32'h0200064A);
    t = 0;
    m0 = 0;
    for (int i = 0; i < 32; i++) begin
      rd(ADR + i, 1'b0, n, m);
      if (i == 0) m0 = m;
      t += n;
    end
    idle();
    chk("run ticks", 42, (t - m0 + 4) / 8 + 1);
    chk("burst use", 4'hF, burst);
    repeat (12) @(posedge sys_clk_in);
    chk("predicted column", {5'h00, ADR[8:0] + 9'h01F}, m_col[14:1]);
    rd(ADR + 32, 1'b0, n, m);
    chk("idle breaks run", 1, m >= 0);
    // the next column stands on the pins, deselected, before it is asked for
    chk("predicted pins", {1'b1, 5'h00, ADR[8:0] + 9'h021, 1'b0},
      {pins.cs_n, pins.addr});
    rd(ADR + 33, 1'b0, n, m);
    chk("sequential hit", 1, m < 0);
    rd(ADR + 100, 1'b0, n, m);
    idle();
    chk("broken run ticks", 20, (n + 4) / 8);
    cfg(32'h0400064A);
    rd(ADR, 1'b0, n, m);
    rd(ADR + 2, 1'b0, n, m);
    idle();
    chk("stride 2 hit", 1, m < 0);
    chk("burst use", 4'h5, burst);
    // writes run the same sequence, with the extra buffering cycle
    cfg(32'h0300024A);
    acc(1'b1, ADR, 1'b0, n, m);
    idle();
    chk("buffered write ticks", 12, (n - m + 4) / 8 + 1);
    chk("write column", tbl[0].col | 15'h0001, m_col);
    cfg(32'h0200064A);
    rd(ADR, 1'b1, n, m);
    rd(ADR + 2, 1'b1, n, m);
    idle();
    chk("simd hit", 1, m < 0);
    chk("simd burst use", 4'h5, burst);
    aref_req <= 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chk("refresh passed", 1, aref);
    cfg(32'h0A00024A);
    repeat (2) @(negedge sys_clk_in);
    chk("refresh held off", 0, aref);
    // a second reset in mid-run must bring back the power-up state
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk("mid reset outputs", 32'h0000010F, {pready, ack, aref, pins.cmd, burst});
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl0 after reset", 32'h0200024A, q);
    end_sim();
  end
endmodule

// ==== verilog/dam_ctrl.sv ====
// memory address translation with predictive read addressing
`include "dam_regs.svh"
// Behaviour
// [R1] page mode, 8 banks, 12 row, 10 col: row from 23..12, col from 8..0
// [R2] page mode, 4 banks, 11 col: bank 11..10, row 23..12, col A11 bit 9
// [R3] bank mode, 8 banks, 10 col: bank 23..21, row 20..9, col 8..0
// [R4] bank mode, 4 banks, 11 col: bank 23..22, row 21..10, col A11 bit 9
// [R5] each word is two half accesses, column A0 low then high; a predicted hit issues one read with A0 low
// [R6] control bit 14 selects page (0, default) or bank (1) mapping
// [R7] other widths map alike: column lowest, bank above column or row
// [R8] parallel parts form one external bank with one select
// [R9] page size follows from the configured column width
// [R10] control bit 24 adds one buffering cycle to every unpredicted access
// [R11] prediction drives address plus stride onto the pins early; done only after an unpredicted read, a hit only updates pred_reg
// [R12] unpredicted read takes 11 memory clocks
// [R13] predicted sequential reads take one memory clock each
// [R14] software keeps prediction away from external bank boundaries
// [R15] stride 1 uses every burst word, stride 2 every second one
// [R16] simd reads with prediction use stride 2 always
// [R17] a broken predicted run costs eight discarded reads
// [R18] an idle memory clock between reads breaks the sequence
// [R19] higher priority requester should use the programmed stride
// [R20] in self-refresh no auto-refresh command is issued
module dam_ctrl #(
  parameter int unsigned READ_CYCLES = `DAM_RD_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // requester
  input wire logic req_valid_in,
  input wire dam_pkg::dam_req_s req_in,
  output logic ack_out,
  output logic [3:0] burst_use_out,
  // memory side
  input wire logic memory_clock_in,
  output dam_pkg::dam_pins_s pins_out,
  // refresh
  input wire logic auto_refresh_req_in,
  output logic auto_refresh_out
);
  logic [2:0] mclk_reg, mclk_next;
  logic mtick;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic ref_reg, ref_next;
  logic ilv, opt, regbuf, sref;
  logic [1:0] bc, caw, stride_field;
  logic [2:0] raw;
  logic [3:0] col_w, n_c, row_w;
  logic [1:0] nbb;
  logic [4:0] row_sh, bank_sh;
  logic [31:0] bank_mask;
  logic [11:0] page_words;
  logic [1:0] req_stride, cur_stride;
  logic [4:0] run_last;
  logic hit, busy;
  logic [31:0] stat_word;
  dam_pkg::dam_state_e state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  dam_pkg::dam_req_s cur_reg, cur_next;
  logic [31:0] pred_reg, pred_next;
  logic pok_reg, pok_next;
  dam_pkg::dam_pins_s pins_reg, pins_next;
  logic ack_reg, ack_next;
  logic [3:0] use_reg, use_next;
  logic [3:0] disc_reg, disc_next;

  // memory clock is foreign: two stages, then edge detect on the settled copy
  always_comb mclk_next = {mclk_reg[1:0], memory_clock_in};
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mclk_reg <= 3'h0;
    end else begin
      mclk_reg <= mclk_next;
    end
  end
  assign mtick = mclk_reg[1] & ~mclk_reg[2];

  // configuration decode
  assign ilv = ctrl_reg[`DAM_ILV_BIT]; // [R6]
  assign opt = ctrl_reg[`DAM_OPT_BIT];
  assign regbuf = ctrl_reg[`DAM_REGBUF_BIT];
  assign sref = ctrl_reg[`DAM_SREF_BIT];
  assign bc = ctrl_reg[`DAM_BC_LSB +: 2];
  assign caw = ctrl_reg[`DAM_CAW_LSB +: 2];
  assign raw = ctrl_reg[`DAM_RAW_LSB +: 3];
  assign stride_field = ctrl_reg[`DAM_STRIDE_LSB +: 2];
  assign col_w = `DAM_COL_BASE + {2'h0, caw};
  // the half-word bit takes column A0, so the word address gives one bit less
  assign n_c = col_w - 4'h1;
  assign row_w = `DAM_ROW_BASE + {1'h0, raw};
  assign nbb = (bc == 2'h1) ? 2'h2 : 2'h3;
  assign bank_mask = (bc == 2'h1) ? 32'h3 : 32'h7;
  assign row_sh = ilv ? 5'(n_c) : 5'(n_c + {2'h0, nbb}); // [R6] [R7]
  assign bank_sh = ilv ? 5'(n_c) + 5'(row_w) : 5'(n_c); // [R6] [R7]
  assign page_words = 12'h001 << n_c; // [R9]
  // a zero stride would predict the same word; treat it as one
  assign req_stride = (opt & req_in.simd) ? 2'h2 :
                      (stride_field == 2'h0) ? 2'h1 : stride_field; // [R16]
  assign cur_stride = (opt & cur_reg.simd) ? 2'h2 :
                      (stride_field == 2'h0) ? 2'h1 : stride_field; // [R16]
  assign run_last = 5'(READ_CYCLES - 1) + {4'h0, regbuf}; // [R10] [R12]
  assign hit = opt & pok_reg & ~req_in.write & (req_in.addr == pred_reg); // [R13]
  assign busy = (state_reg != dam_pkg::DAM_ST_IDLE);

  // row/bank or column pin image of a word address
  function automatic dam_pkg::dam_pins_s map_word(input logic [31:0] word_addr,
                                                input logic col, input logic half);
    logic [31:0] colv;
    logic [31:0] rowv;
    logic [31:0] bankv;
    dam_pkg::dam_pins_s p;
    colv = word_addr & ((32'h1 << n_c) - 32'h1);
    rowv = (word_addr >> row_sh) & ((32'h1 << row_w) - 32'h1);
    bankv = (word_addr >> bank_sh) & bank_mask;
    p.cmd = dam_pkg::DAM_CMD_NOP;
    p.cs_n = 1'b1;
    p.ba = bankv[2:0]; // [R1] [R2] [R3] [R4] [R7]
    p.addr = rowv[14:0]; // [R1] [R2] [R3] [R4] [R7]
    if (col) begin
      p.addr = 15'h0000;
      p.addr[0] = half; // [R5]
      // A10 is skipped in the column phase, it stays low (no auto-precharge)
      for (int k = 1; k < 15; k++) begin
        if (k < 10) begin
          p.addr[k] = colv[k - 1]; // [R1] [R3] [R7]
        end else if (k > 10) begin
          p.addr[k] = colv[k - 2]; // [R2] [R4] [R7]
        end
      end
    end
    return p;
  endfunction

  // apb registers
  assign stat_word = {4'h0, page_words, 8'h00, 1'b0, disc_reg, pok_reg, sref, busy};
  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    if (psel_in & penable_in & pwrite_in & (paddr_in == `DAM_CTRL0_OFS)) begin
      ctrl_next = pwdata_in & `DAM_CTRL0_MASK;
    end
    if (psel_in & ~penable_in & ~pwrite_in) begin
      if (paddr_in == `DAM_CTRL0_OFS) begin
        prdata_next = ctrl_reg;
      end else if (paddr_in == `DAM_STAT_OFS) begin
        prdata_next = stat_word;
      end else begin
        prdata_next = 32'h00000000;
      end
    end
    ref_next = auto_refresh_req_in & ~sref; // [R20]
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= `DAM_CTRL0_RST;
      prdata_reg <= 32'h00000000;
      ref_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      ref_reg <= ref_next;
    end
  end
  assign prdata_out = prdata_reg;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in &
                       (paddr_in != `DAM_CTRL0_OFS) & (paddr_in != `DAM_STAT_OFS);
  assign auto_refresh_out = ref_reg;

  // access sequencer, stepped once per memory clock
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cur_next = cur_reg;
    pred_next = pred_reg;
    pok_next = pok_reg;
    pins_next = pins_reg;
    ack_next = 1'b0;
    use_next = use_reg;
    disc_next = disc_reg;
    if (mtick) begin
      pins_next.cmd = dam_pkg::DAM_CMD_NOP;
      unique case (state_reg)
        dam_pkg::DAM_ST_IDLE: begin
          if (req_valid_in) begin
            cur_next = req_in;
            use_next = (req_stride == 2'h2) ? 4'h5 : 4'hF; // [R15]
            if (hit) begin
              // the predicted column is driven together with the read command, no activate needed
              pins_next = map_word(pred_reg, 1'b1, 1'b0); // [R13]
              pins_next.cmd = dam_pkg::DAM_CMD_RD;
              ack_next = 1'b1;
              pred_next = req_in.addr + 32'(req_stride); // [R11]
            end else if (opt & pok_reg & ~req_in.write) begin
              state_next = dam_pkg::DAM_ST_DISC; // [R17]
              cnt_next = 5'(`DAM_DISCARD_MAX);
              disc_next = 4'(`DAM_DISCARD_MAX);
              pok_next = 1'b0;
            end else begin
              state_next = dam_pkg::DAM_ST_RUN;
              cnt_next = 5'h01;
              pins_next = map_word(req_in.addr, 1'b0, 1'b0);
              pins_next.cmd = dam_pkg::DAM_CMD_ACT;
              pok_next = 1'b0;
            end
          end else begin
            pok_next = 1'b0; // [R18]
          end
        end
        dam_pkg::DAM_ST_DISC: begin
          if (cnt_reg == 5'h00) begin
            state_next = dam_pkg::DAM_ST_RUN;
            cnt_next = 5'h01;
            pins_next = map_word(cur_reg.addr, 1'b0, 1'b0);
            pins_next.cmd = dam_pkg::DAM_CMD_ACT;
          end else begin
            // reads already in flight for the stale prediction are thrown away
            pins_next.cmd = dam_pkg::DAM_CMD_RD; // [R17]
            cnt_next = cnt_reg - 5'h01;
          end
        end
        dam_pkg::DAM_ST_RUN: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(`DAM_COL0_CYC) || cnt_reg == 5'(`DAM_COL0_CYC + `DAM_CCD)) begin
            pins_next = map_word(cur_reg.addr, 1'b1, cnt_reg != 5'(`DAM_COL0_CYC)); // [R5]
            pins_next.cmd = cur_reg.write ? dam_pkg::DAM_CMD_WR : dam_pkg::DAM_CMD_RD;
          end
          if (cnt_reg == run_last) begin
            state_next = dam_pkg::DAM_ST_IDLE; // [R10] [R12]
            ack_next = 1'b1;
            if (opt & ~cur_reg.write) begin
              pred_next = cur_reg.addr + 32'(cur_stride); // [R11]
              pok_next = 1'b1;
              pins_next = map_word(cur_reg.addr + 32'(cur_stride), 1'b1, 1'b0); // [R11]
            end
          end
        end
        default: begin
          state_next = dam_pkg::DAM_ST_IDLE;
        end
      endcase
      // one select line for the whole cluster of parallel parts
      pins_next.cs_n = (pins_next.cmd == dam_pkg::DAM_CMD_NOP); // [R8]
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= dam_pkg::DAM_ST_IDLE;
      cnt_reg <= 5'h00;
      cur_reg <= '0;
      pred_reg <= 32'h00000000;
      pok_reg <= 1'b0;
      pins_reg <= {dam_pkg::DAM_CMD_NOP, 1'b1, 3'h0, 15'h0000};
      ack_reg <= 1'b0;
      use_reg <= 4'hF;
      disc_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cur_reg <= cur_next;
      pred_reg <= pred_next;
      pok_reg <= pok_next;
      pins_reg <= pins_next;
      ack_reg <= ack_next;
      use_reg <= use_next;
      disc_reg <= disc_next;
    end
  end
  assign ack_out = ack_reg;
  assign burst_use_out = use_reg;
  assign pins_out = pins_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_page_map8: assert property ( // [R1]
    (pins_reg.cmd == dam_pkg::DAM_CMD_ACT && !ilv && bc == 2'h2 && raw == 3'h4 && caw == 2'h2)
    |-> (pins_reg.addr[11:0] == cur_reg.addr[23:12] && pins_reg.ba == cur_reg.addr[11:9]))
    else $error("page map with eight banks is wrong");
  chk_page_map4: assert property ( // [R2]
    (pins_reg.cmd == dam_pkg::DAM_CMD_ACT && !ilv && bc == 2'h1 && raw == 3'h4 && caw == 2'h3)
    |-> (pins_reg.addr[11:0] == cur_reg.addr[23:12] && pins_reg.ba[1:0] == cur_reg.addr[11:10]))
    else $error("page map with four banks is wrong");
  chk_bank_map8: assert property ( // [R3]
    (pins_reg.cmd == dam_pkg::DAM_CMD_ACT && ilv && bc == 2'h2 && raw == 3'h4 && caw == 2'h2)
    |-> (pins_reg.addr[11:0] == cur_reg.addr[20:9] && pins_reg.ba == cur_reg.addr[23:21]))
    else $error("bank map with eight banks is wrong");
  chk_bank_map4: assert property ( // [R4]
    (pins_reg.cmd == dam_pkg::DAM_CMD_ACT && ilv && bc == 2'h1 && raw == 3'h4 && caw == 2'h3)
    |-> (pins_reg.addr[11:0] == cur_reg.addr[21:10] && pins_reg.ba[1:0] == cur_reg.addr[23:22]))
    else $error("bank map with four banks is wrong");
  chk_half_order: assert property ( // [R5]
    (state_reg == dam_pkg::DAM_ST_RUN && pins_reg.cmd inside {dam_pkg::DAM_CMD_RD,
     dam_pkg::DAM_CMD_WR}) |-> (pins_reg.addr[9:1] == cur_reg.addr[8:0] &&
     pins_reg.addr[0] == (cnt_reg == 5'(`DAM_COL0_CYC + `DAM_CCD + 1))))
    else $error("half-word column order is wrong");
  chk_run_length: assert property ( // [R12]
    (ack_reg && $past(state_reg) == dam_pkg::DAM_ST_RUN)
    |-> ($past(cnt_reg) == 5'(READ_CYCLES - 1) + {4'h0, regbuf}))
    else $error("access length is wrong");
  chk_hit_single: assert property ( // [R13]
    (state_reg == dam_pkg::DAM_ST_IDLE && mtick && req_valid_in && hit)
    |=> (ack_reg && pins_reg.cmd == dam_pkg::DAM_CMD_RD && state_reg == dam_pkg::DAM_ST_IDLE))
    else $error("predicted read not served in one memory clock");
  chk_pred_next: assert property ( // [R11]
    (ack_reg && pok_reg) |-> (pred_reg == cur_reg.addr + 32'(cur_stride)))
    else $error("predicted address is not address plus stride");
  chk_use_mask: assert property ( // [R15]
    (ack_reg) |-> (use_reg == ((cur_stride == 2'h2) ? 4'h5 : 4'hF)))
    else $error("burst word selection is wrong");
  chk_simd_two: assert property ( // [R16]
    (state_reg == dam_pkg::DAM_ST_IDLE && mtick && req_valid_in && req_in.simd && opt)
    |=> (use_reg == 4'h5))
    else $error("simd read did not use stride two");
  chk_idle_break: assert property ( // [R18]
    (state_reg == dam_pkg::DAM_ST_IDLE && mtick && !req_valid_in) |=> !pok_reg)
    else $error("idle memory clock kept the sequence");
  chk_discard_len: assert property ( // [R17]
    (state_reg != dam_pkg::DAM_ST_DISC ##1 state_reg == dam_pkg::DAM_ST_DISC)
    |-> (cnt_reg == 5'(`DAM_DISCARD_MAX)))
    else $error("discard run has the wrong length");
  chk_no_refresh: assert property ( // [R20]
    ($past(sref) && sref) |-> !auto_refresh_out)
    else $error("auto-refresh issued in self-refresh");
  chk_page_size: assert property ( // [R9]
    (caw == 2'h2) |-> (page_words == 12'h200))
    else $error("page size does not follow column width");

  cov_hit: cover property (ack_reg && $past(hit));
  cov_discard: cover property (state_reg == dam_pkg::DAM_ST_DISC);
  cov_buffered: cover property (ack_reg && regbuf);
  cov_simd: cover property (ack_reg && cur_reg.simd && opt);
endmodule
